// [pkg/rbgt_regs.svh]
`ifndef RBGT_REGS_SVH
`define RBGT_REGS_SVH

// Serial clock divider
`define RBGT_DIV_LAST 4'h9
`define RBGT_DIV_HALF 4'h5

// Peripheral addresses on A0..A4
`define RBGT_ADDR_UART_LAST 5'h07
`define RBGT_ADDR_TIMER 5'h10
`define RBGT_ADDR_SOFT_RESET 5'h11
`define RBGT_ADDR_BOARD_ID 5'h12
`define RBGT_TIMER_RUN_BIT 0

// Soft reset stretch in clk cycles
`define RBGT_SOFT_RESET_CYCLES 4'h8

// Sensor sequence: phase lengths in serial clock periods, then pixel count
`define RBGT_GATE_TICKS 8'h04
`define RBGT_CONV_TICKS 8'h02
`define RBGT_PIXELS 12'h800

`endif

// [pkg/rbgt_pkg.sv]
package rbgt_pkg;

  typedef logic [13:0] rbgt_addr_t;
  typedef logic [10:0] rbgt_data_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_GATE  = 3'b001,
    ST_RESET = 3'b010,
    ST_CDS_BASELINE_SAMPLE  = 3'b011,
    ST_SHIFT = 3'b100,
    ST_PEAK  = 3'b101,
    ST_CONV  = 3'b110
  } rbgt_seq_state_t;

endpackage

// [pkg/rbgt_seq_if.sv]
`timescale 1ns/100ps
interface rbgt_seq_if;
  logic clkEn;
  logic runEnable;
  logic serialTick;
  logic shiftClockN;
  logic resetPulseN;
  logic readoutGateN;
  logic baselineSample;
  logic peakSample;
  logic converterSelectN;
  logic startFlag;

  modport ctrl (
    output clkEn, runEnable, serialTick,
    input shiftClockN, resetPulseN, readoutGateN, baselineSample, peakSample, converterSelectN, startFlag
  );
  modport seq (
    input clkEn, runEnable, serialTick,
    output shiftClockN, resetPulseN, readoutGateN, baselineSample, peakSample, converterSelectN, startFlag
  );
endinterface

// [hdl/rbgt_sensor_seq.sv]
`timescale 1ns/100ps
`include "rbgt_regs.svh"
module rbgt_sensor_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Glue side
  rbgt_seq_if.seq sq
);
  import rbgt_pkg::*;

  rbgt_seq_state_t state;
  rbgt_seq_state_t next_state;
  logic [7:0] tickCount;
  logic [11:0] pixel;
  logic tickEnd;
  logic advance;
  logic convDone;

  assign advance = sq.clkEn && sq.serialTick;
  assign tickEnd = (state == ST_GATE) ? (tickCount == `RBGT_GATE_TICKS - 8'h01) :
                   (state == ST_CONV) ? (tickCount == `RBGT_CONV_TICKS - 8'h01) : 1'b1;
  assign convDone = (state == ST_CONV) && tickEnd;

  // Starts only with the timer run bit set; once it drops, stops in ST_GATE or at the end of ST_CONV
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sq.runEnable) next_state = ST_GATE;
      end
      ST_GATE: begin
        if (!sq.runEnable) next_state = ST_IDLE;
        else if (tickEnd) next_state = ST_RESET;
      end
      ST_RESET: next_state = ST_CDS_BASELINE_SAMPLE;
      ST_CDS_BASELINE_SAMPLE: next_state = ST_SHIFT;
      ST_SHIFT: next_state = ST_PEAK;
      ST_PEAK: next_state = ST_CONV;
      ST_CONV: begin
        // Pixel is always finished before stopping
        if (tickEnd) begin
          if (!sq.runEnable) next_state = ST_IDLE;
          else if (pixel == `RBGT_PIXELS - 12'h001) next_state = ST_GATE;
          else next_state = ST_RESET;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      tickCount <= 8'h00;
    end else if (advance) begin
      state <= next_state;
      tickCount <= (next_state != state) ? 8'h00 : tickCount + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pixel <= 12'h000;
    end else if (advance) begin
      if (state == ST_IDLE || state == ST_GATE) pixel <= 12'h000;
      else if (convDone) pixel <= pixel + 12'h001;
    end
  end

  // Registered drive, one clk behind state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sq.readoutGateN <= 1'b1;
      sq.resetPulseN <= 1'b1;
      sq.baselineSample <= 1'b0;
      sq.shiftClockN <= 1'b1;
      sq.peakSample <= 1'b0;
      sq.converterSelectN <= 1'b1;
      sq.startFlag <= 1'b0;
    end else if (sq.clkEn) begin
      sq.readoutGateN <= !(state == ST_GATE);
      sq.resetPulseN <= !(state == ST_RESET);
      sq.baselineSample <= (state == ST_CDS_BASELINE_SAMPLE);
      sq.shiftClockN <= !(state == ST_SHIFT);
      sq.peakSample <= (state == ST_PEAK);
      sq.converterSelectN <= !(state == ST_CONV);
      sq.startFlag <= sq.serialTick && convDone;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sConvEnd;
    sq.clkEn && sq.serialTick && convDone;
  endsequence

  sequence sIdleNoRun;
    state == ST_IDLE && !sq.runEnable;
  endsequence

  chk_start_flag_end: assert property (sConvEnd |=> sq.startFlag)
    else $error("conversion start flag missing at end of conversion");
  chk_start_flag_single: assert property (sq.startFlag && sq.clkEn |=> !sq.startFlag)
    else $error("conversion start flag longer than one cycle");
  chk_seq_stays_idle: assert property (sIdleNoRun |=> state == ST_IDLE)
    else $error("sensor sequence ran without run bit");
  chk_seq_idle_quiet: assert property (sIdleNoRun ##1 sq.clkEn |=>
      sq.readoutGateN && sq.resetPulseN && sq.converterSelectN && !sq.peakSample)
    else $error("sensor outputs active while idle");
  chk_run_drop_stop: assert property (sConvEnd ##0 !sq.runEnable |=> state == ST_IDLE)
    else $error("sequence kept running after run bit dropped");
endmodule

// [hdl/rbgt_glue.sv]
`timescale 1ns/100ps
`include "rbgt_regs.svh"
// Operation
// - Divide input clock by ten, free running
// - Divided clock shared by all serial links
// - Sensor sequence runs only when processor enables
// - Timer enabled by write of data bit 0 at address 16
// - Run bit starts and sustains conversion
// - Qualify by select, strobe and A0..A4
// - Higher addresses are never peripheral accesses
// - Addresses 0..7 select UART with strobes
// - Read at 18 opens board number gates
// - UART interrupt passed on inverted
// - Active board flag inverted to LVDS gates
// - Processor reset from monitor or address 17
// - Test select and clock forwarded, data chained
// - Processor reset is inverse of monitor reset or soft reset
module rbgt_glue (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Processor bus
  input wire rbgt_pkg::rbgt_addr_t busAddr,
  input wire rbgt_pkg::rbgt_data_t busData,
  input wire logic ioSpaceSelectN,
  input wire logic bootSpaceSelectN,
  input wire logic busReadN,
  input wire logic busWriteN,
  // Peripheral strobes
  output logic uartSelectN,
  output logic uartReadN,
  output logic uartWriteN,
  output logic boardIdGateN,
  // Interrupt and board selection
  input wire logic uartIrq,
  output logic uartIrqN,
  input wire logic boardSelected,
  output logic boardSelectedN,
  // Processor reset
  input wire logic monitorReset,
  output logic processorResetN,
  // Peripheral serial clock
  output logic periphSerialClockHv,
  // Sensor and converter control
  output logic sensorShiftClockN,
  output logic sensorResetPulseN,
  output logic sensorReadoutGateN,
  output logic cdsBaselineSample,
  output logic cdsPeakSample,
  output logic converterSelectN,
  output logic conversionStartFlag,
  // Test chain
  input wire logic testModeIn,
  input wire logic testClockIn,
  input wire logic testDataIn,
  output logic testModeDown,
  output logic testClockDown,
  output logic testDataDown
);
  import rbgt_pkg::*;

  rbgt_seq_if sq ();

  logic [3:0] divCount;
  logic serialTick;
  logic ioAccess;
  logic strobe;
  logic timerRun;
  logic softHit;
  logic softHitPrev;
  logic [3:0] softCount;
  logic softActive;
  logic testClockPrev;
  logic bypassBit;

  // Low five address lines against a peripheral address
  function automatic logic addrIs(input rbgt_addr_t a, input logic [4:0] target);
    addrIs = (a[4:0] == target);
  endfunction

  // Free running divider, not gated by any command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= 4'h0;
    end else if (clkEn) begin
      divCount <= (divCount == `RBGT_DIV_LAST) ? 4'h0 : divCount + 4'h1;
    end
  end

  // Low half then high half, so duty is exactly 50 %
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periphSerialClockHv <= 1'b0;
    end else if (clkEn) begin
      if (divCount == `RBGT_DIV_HALF - 4'h1) periphSerialClockHv <= 1'b1;
      else if (divCount == `RBGT_DIV_LAST) periphSerialClockHv <= 1'b0;
    end
  end

  // Sequencer steps once per serial clock period
  assign serialTick = (divCount == `RBGT_DIV_LAST);

  // Upper address lines belong to the processor itself and flash
  assign ioAccess = !ioSpaceSelectN && bootSpaceSelectN && (busAddr[13:5] == 9'h000);
  assign strobe = !busReadN || !busWriteN;

  always_comb begin
    uartSelectN = 1'b1;
    uartReadN = 1'b1;
    uartWriteN = 1'b1;
    boardIdGateN = 1'b1;
    if (ioAccess && strobe && (busAddr[4:0] <= `RBGT_ADDR_UART_LAST)) begin
      uartSelectN = 1'b0;
      uartReadN = busReadN;
      uartWriteN = busWriteN;
    end
    if (ioAccess && !busReadN && addrIs(busAddr, `RBGT_ADDR_BOARD_ID)) begin
      boardIdGateN = 1'b0;
    end
  end

  // Run bit follows every write to the timer address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timerRun <= 1'b0;
    end else if (clkEn && ioAccess && !busWriteN && addrIs(busAddr, `RBGT_ADDR_TIMER)) begin
      timerRun <= busData[`RBGT_TIMER_RUN_BIT];
    end
  end

  assign softHit = ioAccess && strobe && addrIs(busAddr, `RBGT_ADDR_SOFT_RESET);

  // Strobe may be one cycle; stretch so the processor sees it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      softHitPrev <= 1'b0;
      softCount <= 4'h0;
    end else if (clkEn) begin
      softHitPrev <= softHit;
      if (softHit && !softHitPrev) softCount <= `RBGT_SOFT_RESET_CYCLES;
      else if (softCount != 4'h0) softCount <= softCount - 4'h1;
    end
  end

  assign softActive = (softCount != 4'h0);
  // Monitor path is combinational so it works with clk stopped
  assign processorResetN = !(monitorReset || softActive);

  assign uartIrqN = !uartIrq;
  assign boardSelectedN = !boardSelected;

  // Test chain: select and clock pass straight downstream
  assign testModeDown = testModeIn;
  assign testClockDown = testClockIn;

  // One bit bypass stage, shifted on test clock edges seen by clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      testClockPrev <= 1'b0;
      bypassBit <= 1'b0;
      testDataDown <= 1'b0;
    end else if (clkEn) begin
      testClockPrev <= testClockIn;
      if (testClockIn && !testClockPrev) bypassBit <= testDataIn;
      if (!testClockIn && testClockPrev) testDataDown <= bypassBit;
    end
  end

  assign sq.clkEn = clkEn;
  assign sq.runEnable = timerRun;
  assign sq.serialTick = serialTick;

  rbgt_sensor_seq seqUnit (
    .clk(clk),
    .rst_b(rst_b),
    .sq(sq)
  );

  assign sensorShiftClockN = sq.shiftClockN;
  assign sensorResetPulseN = sq.resetPulseN;
  assign sensorReadoutGateN = sq.readoutGateN;
  assign cdsBaselineSample = sq.baselineSample;
  assign cdsPeakSample = sq.peakSample;
  assign converterSelectN = sq.converterSelectN;
  assign conversionStartFlag = sq.startFlag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sSoftStart;
    clkEn && softHit && !softHitPrev;
  endsequence

  sequence sRunWrite;
    clkEn && ioAccess && !busWriteN && addrIs(busAddr, `RBGT_ADDR_TIMER);
  endsequence

  chk_div_range: assert property (divCount <= `RBGT_DIV_LAST)
    else $error("divider count out of range");
  chk_div_high_half: assert property (periphSerialClockHv == (divCount >= `RBGT_DIV_HALF))
    else $error("serial clock phase disagrees with divider");
  chk_div_fall: assert property (clkEn && divCount == `RBGT_DIV_LAST |=> !periphSerialClockHv && divCount == 4'h0)
    else $error("serial clock did not fall at wrap");
  chk_high_addr_ignored: assert property (busAddr[13:5] != 9'h000 |-> uartSelectN && boardIdGateN)
    else $error("high address decoded as peripheral");
  chk_uart_select: assert property (ioAccess && !busReadN && busAddr[4:0] <= 5'h07 |->
      !uartSelectN && !uartReadN && uartWriteN)
    else $error("UART read not decoded");
  chk_board_gate: assert property (!boardIdGateN |-> ioAccess && !busReadN && busAddr[4:0] == 5'h12)
    else $error("board gate opened outside read at 18");
  chk_irq_invert: assert property (uartIrqN != uartIrq)
    else $error("interrupt not inverted");
  chk_active_invert: assert property (boardSelectedN != boardSelected)
    else $error("active flag not inverted");
  chk_run_bit_latch: assert property (sRunWrite |=> timerRun == $past(busData[0]))
    else $error("run bit not taken from data bit 0");
  chk_soft_reset_hold: assert property (sSoftStart |=> !processorResetN[*8])
    else $error("soft reset shorter than eight cycles");
  chk_monitor_reset: assert property (monitorReset |-> !processorResetN)
    else $error("monitor reset not passed to processor");
  chk_test_chain: assert property (testModeDown == testModeIn && testClockDown == testClockIn)
    else $error("test select or clock not forwarded");
endmodule

// [verif/rbgt_dsp_bus.sv]
`timescale 1ns/100ps
module rbgt_dsp_bus (
  // Processor bus
  output rbgt_pkg::rbgt_addr_t busAddr,
  output rbgt_pkg::rbgt_data_t busData,
  output logic ioSpaceSelectN,
  output logic bootSpaceSelectN,
  output logic busReadN,
  output logic busWriteN
);
  import rbgt_pkg::*;

  initial begin
    busAddr = 14'h0000;
    busData = 11'h000;
    ioSpaceSelectN = 1'b1;
    bootSpaceSelectN = 1'b1;
    busReadN = 1'b1;
    busWriteN = 1'b1;
  end

  // Pass bootN low only when a scenario wants the access refused
  task automatic drive(input rbgt_addr_t a, input rbgt_data_t d, input logic rd, input logic bootN);
    busAddr = a;
    busData = d;
    ioSpaceSelectN = 1'b0;
    bootSpaceSelectN = bootN;
    busReadN = !rd;
    busWriteN = rd;
  endtask

  // Released lines flip so a stale value never looks valid
  task automatic idle;
    ioSpaceSelectN = 1'b1;
    bootSpaceSelectN = 1'b1;
    busReadN = 1'b1;
    busWriteN = 1'b1;
    busAddr = ~busAddr;
    busData = ~busData;
  endtask
endmodule

// [verif/rbgt_glue_bench.sv]
`timescale 1ns/100ps
module rbgt_glue_bench;
  import rbgt_pkg::*;
  logic clk, rst_b, clkEn, uartIrq, boardSelected, monitorReset;
  logic testModeIn, testClockIn, testDataIn;
  rbgt_addr_t busAddr;
  rbgt_data_t busData;
  logic ioSpaceSelectN, bootSpaceSelectN, busReadN, busWriteN;
  logic uartSelectN, uartReadN, uartWriteN, boardIdGateN, uartIrqN, boardSelectedN, processorResetN;
  logic periphSerialClockHv, sensorShiftClockN, sensorResetPulseN, sensorReadoutGateN;
  logic cdsBaselineSample, cdsPeakSample, converterSelectN, conversionStartFlag;
  logic testModeDown, testClockDown, testDataDown;
  int errors = 0;
  int checksDone = 0;

  rbgt_dsp_bus bus (.busAddr, .busData, .ioSpaceSelectN, .bootSpaceSelectN, .busReadN, .busWriteN);
  rbgt_glue dut (.clk, .rst_b, .clkEn, .busAddr, .busData, .ioSpaceSelectN, .bootSpaceSelectN,
    .busReadN, .busWriteN, .uartSelectN, .uartReadN, .uartWriteN, .boardIdGateN, .uartIrq, .uartIrqN,
    .boardSelected, .boardSelectedN, .monitorReset, .processorResetN, .periphSerialClockHv,
    .sensorShiftClockN, .sensorResetPulseN, .sensorReadoutGateN, .cdsBaselineSample, .cdsPeakSample,
    .converterSelectN, .conversionStartFlag, .testModeIn, .testClockIn, .testDataIn, .testModeDown,
    .testClockDown, .testDataDown);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && checksDone > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One combinational look at the strobes while the access stands
  task automatic peek(input rbgt_addr_t a, input logic rd, input logic bootN, input logic [3:0] exp);
    bus.drive(a, 11'h000, rd, bootN);
    #5;
    check({uartSelectN, uartReadN, uartWriteN, boardIdGateN}, exp);
    step(1);
    bus.idle();
    step(1);
  endtask

  task automatic decodeSweep;
    for (int a = 0; a < 16; a++) begin
      peek(a[13:0], 1'b1, 1'b1, (a < 8) ? 4'h3 : 4'hf);
      peek(a[13:0], 1'b0, 1'b1, (a < 8) ? 4'h5 : 4'hf);
    end
    peek(14'h0012, 1'b1, 1'b1, 4'he);
    peek(14'h0012, 1'b0, 1'b1, 4'hf);
    peek(14'h0023, 1'b1, 1'b1, 4'hf);
    peek(14'h2003, 1'b0, 1'b1, 4'hf);
    peek(14'h0003, 1'b1, 1'b0, 4'hf);
  endtask

  task automatic passThrough;
    for (int v = 0; v < 4; v++) begin
      {uartIrq, boardSelected} = v[1:0];
      monitorReset = v[0];
      testModeIn = v[1];
      testClockIn = v[0];
      #5;
      check({uartIrqN, boardSelectedN}, ~v[1:0] & 2'h3);
      check(processorResetN, !v[0]);
      check({testModeDown, testClockDown}, {v[1], v[0]});
      step(1);
    end
    monitorReset = 1'b0;
    testClockIn = 1'b0;
    step(2);
  endtask

  task automatic softReset;
    int n;
    bus.drive(14'h0011, 11'h000, 1'b0, 1'b1);
    step(1);
    bus.idle();
    n = 0;
    repeat (20) begin
      n += !processorResetN;
      step(1);
    end
    check(n, 8);
  endtask

  task automatic testChain(input logic bit1);
    testDataIn = bit1;
    testClockIn = 1'b1;
    step(3);
    testDataIn = !bit1;
    testClockIn = 1'b0;
    step(3);
    check(testDataDown, bit1);
  endtask

  task automatic serialClock;
    int n, h;
    logic prev;
    logic held;
    n = 0;
    h = 0;
    while (periphSerialClockHv !== 1'b0 && n < 20) begin step(1); n++; end
    while (periphSerialClockHv !== 1'b1 && n < 40) begin step(1); n++; end
    // Count from one rising edge to the next
    n = 0;
    prev = 1'b1;
    do begin
      h += periphSerialClockHv;
      prev = periphSerialClockHv;
      step(1);
      n++;
    end while (!(periphSerialClockHv === 1'b1 && prev === 1'b0) && n < 30);
    check(n, 10);
    check(h, 5);
    // Enable low must freeze the divider across a would-be edge
    held = periphSerialClockHv;
    clkEn = 1'b0;
    step(7);
    check(periphSerialClockHv, held);
    clkEn = 1'b1;
    step(1);
  endtask

  task automatic timerRun;
    int n;
    bus.drive(14'h0010, 11'h001, 1'b1, 1'b1);
    step(1);
    bus.idle();
    step(30);
    check({sensorReadoutGateN, converterSelectN, cdsBaselineSample}, 3'h6);
    bus.drive(14'h0010, 11'h001, 1'b0, 1'b1);
    step(1);
    bus.idle();
    n = 0;
    while (sensorReadoutGateN !== 1'b0 && n < 30) begin step(1); n++; end
    check(n < 12, 1'b1);
    n = 0;
    while (sensorReadoutGateN === 1'b0 && n < 100) begin step(1); n++; end
    check(n, 40);
    check(sensorResetPulseN, 1'b0);
    step(10);
    check({sensorResetPulseN, cdsBaselineSample}, 2'h3);
    step(10);
    check({cdsBaselineSample, sensorShiftClockN}, 2'h0);
    step(10);
    check({sensorShiftClockN, cdsPeakSample}, 2'h3);
    step(10);
    check({cdsPeakSample, converterSelectN}, 2'h0);
    n = 0;
    while (conversionStartFlag !== 1'b1 && n < 200) begin step(1); n++; end
    check(n < 200, 1'b1);
    step(1);
    check(conversionStartFlag, 1'b0);
    bus.drive(14'h0010, 11'h000, 1'b0, 1'b1);
    step(1);
    bus.idle();
    step(100);
    n = 0;
    repeat (200) begin
      n += !converterSelectN;
      step(1);
    end
    check(n, 0);
  endtask

  initial begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    {uartIrq, boardSelected, monitorReset} = 3'h0;
    {testModeIn, testClockIn, testDataIn} = 3'h0;
    step(2);
    rst_b = 1'b1;
    step(1);
    decodeSweep();
    passThrough();
    softReset();
    testChain(1'b1);
    testChain(1'b0);
    serialClock();
    timerRun();
    give_verdict();
  end

  // Whole sequence needs about 600 cycles
  initial begin
    #(40 * 5000);
    errors++;
    give_verdict();
  end
endmodule
